// file: rtl/smbc_regs.svh
/*
  Register offsets, field positions, reset values and bus constants of the SMBus
  configuration bank. Assumes inclusion by its bare name from the bank module.
*/
// Summary of operation
// - Observation bits 6:3 return live address straps, strap bit 3 in bit 6.
// - Observation bit 2 reads 1 once the EEPROM load has completed.
// - Writing 1 to observation bit 0 restores all registers; bit self-clears.
// - Observation bit 1 set blocks that soft reset; it self-clears too.
// - Power-down register: bits 7:4 output channels, bits 3:0 input channels.
// - Value 0x00 enables all channels, 0xFF disables all; one bit each.
// - Power-down register acts only while override bit 0 of 0x02 is set.
// - Override bit set blocks the pin; cleared, the pin governs again.
// - Control register bit 3 enables register control in slave mode.
// - Device answers address byte 0xB0 plus twice the four-bit strap value.
// - Read: pointer write, repeated start, one byte, host NACK then STOP.
`ifndef SMBC_REGS_SVH
`define SMBC_REGS_SVH
// ---------------------------------------------------------------------------
// offsets
// ---------------------------------------------------------------------------
`define SMBC_REG_OBS 8'h00
`define SMBC_REG_POWER_DOWN_PIN 8'h01
`define SMBC_REG_OVR 8'h02
`define SMBC_REG_RSVD3 8'h03
`define SMBC_REG_RSVD5 8'h05
`define SMBC_REG_CTL 8'h06
// ---------------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------------
`define SMBC_OBS_RST_BIT 0
`define SMBC_OBS_BLK_BIT 1
`define SMBC_OBS_RSVD_BIT 7
`define SMBC_OVR_BIT 0
`define SMBC_CTL_EN_BIT 3
`define SMBC_ZERO 8'h00
`define SMBC_CTL_RST 8'h10
`define SMBC_RSVD_CNT 3
// ---------------------------------------------------------------------------
// bus framing
// ---------------------------------------------------------------------------
`define SMBC_BASE_ADDR 8'hB0
`define SMBC_BYTE_BITS 4'h8
`define SMBC_LAST_BIT 4'h7
`define SMBC_CNT_ZERO 4'h0
`define SMBC_CNT_ONE 4'h1
`define SMBC_PTR_ONE 8'h01
`endif

// file: rtl/smbc_pkg.sv
/*
  Types of the SMBus configuration bank: bus pin sample and slave states.
  Assumes the users import the whole package.
*/
package smbc_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
  } smbc_bus_t;

  // gray steps along address, pointer and data paths; AACK to RDATA flips three bits
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_REG = 4'h2,
    ST_PACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_DACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_MACK = 4'hC
  } smbc_state_t;
endpackage : smbc_pkg

// file: rtl/smbc_bank.sv
/*
  SMBus slave and low configuration register bank (offsets 0x00 to 0x06).
  Assumes SCL and SDA already synchronous to ref_clk_i and far slower than it;
  the SDA wire is resolved outside from the output enable.
*/
`timescale 1ns/1ps
`include "smbc_regs.svh"
module smbc_bank (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire smbc_pkg::smbc_bus_t smb_i,
  output logic smb_sda_o,
  output logic smb_sda_oe_o,
  input wire logic [3:0] strap_i,
  input wire logic eeprom_done_i,
  input wire logic power_down_pin_i,
  output logic [7:0] chan_off_o,
  output logic reg_ctl_en_o
);
  import smbc_pkg::*;

  // ---------------------------------------------------------------------------
  // bus sampling and framing
  // ---------------------------------------------------------------------------
  smbc_state_t state_q, state_d;
  logic scl_q, sda_q, oe_q, oe_d;
  logic [7:0] shreg_q, shreg_d, ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] power_down_pin_q, ovr_q, ctl_q, chan_off_q;
  logic obs7_q;
  logic [7:0] rsvd_q [`SMBC_RSVD_CNT];

  wire scl_rise = smb_i.scl & ~scl_q;
  wire scl_fall = ~smb_i.scl & scl_q;
  wire start_c = scl_q & smb_i.scl & sda_q & ~smb_i.sda;
  wire stop_c = scl_q & smb_i.scl & ~sda_q & smb_i.sda;
  wire byte_done = scl_fall & (cnt_q == `SMBC_BYTE_BITS);
  wire rx_state = (state_q == ST_ADDR) | (state_q == ST_REG) | (state_q == ST_WDATA);
  wire [7:0] addr_byte = `SMBC_BASE_ADDR + {3'h0, strap_i, 1'b0};
  wire addr_hit = (shreg_q[7:1] == addr_byte[7:1]);
  wire [7:0] ridx = ptr_q - `SMBC_REG_RSVD3;
  wire in_rsvd = (ptr_q >= `SMBC_REG_RSVD3) && (ptr_q <= `SMBC_REG_RSVD5);
  wire wr_en = byte_done & (state_q == ST_WDATA);
  wire obs_wr = wr_en & (ptr_q == `SMBC_REG_OBS);
  // block and reset in one byte: the block wins, only bit 7 is written
  wire soft_rst = obs_wr & shreg_q[`SMBC_OBS_RST_BIT] & ~shreg_q[`SMBC_OBS_BLK_BIT];

  // self-clearing bits 1:0 always read back as zero
  wire [7:0] obs_val = {obs7_q, strap_i, eeprom_done_i, 2'b00};
  // unmapped offsets read as zero
  wire [7:0] rd_data = (ptr_q == `SMBC_REG_OBS) ? obs_val :
                       (ptr_q == `SMBC_REG_POWER_DOWN_PIN) ? power_down_pin_q :
                       (ptr_q == `SMBC_REG_OVR) ? ovr_q :
                       in_rsvd ? rsvd_q[ridx[1:0]] :
                       (ptr_q == `SMBC_REG_CTL) ? ctl_q : `SMBC_ZERO;

  // ---------------------------------------------------------------------------
  // slave sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    if (scl_rise && rx_state) begin
      shreg_d = {shreg_q[6:0], smb_i.sda};
      cnt_d = cnt_q + `SMBC_CNT_ONE;
    end
    case (state_q)
      ST_ADDR: if (byte_done) begin
        cnt_d = `SMBC_CNT_ZERO;
        state_d = addr_hit ? ST_AACK : ST_IDLE;
      end
      ST_AACK: if (scl_fall) begin
        if (shreg_q[0]) begin
          shreg_d = rd_data;
          state_d = ST_RDATA;
        end else begin
          state_d = ST_REG;
        end
      end
      ST_REG: if (byte_done) begin
        ptr_d = shreg_q;
        cnt_d = `SMBC_CNT_ZERO;
        state_d = ST_PACK;
      end
      ST_PACK: if (scl_fall) begin
        state_d = ST_WDATA;
      end
      ST_WDATA: if (byte_done) begin
        ptr_d = ptr_q + `SMBC_PTR_ONE;
        cnt_d = `SMBC_CNT_ZERO;
        state_d = ST_DACK;
      end
      ST_DACK: if (scl_fall) begin
        state_d = ST_WDATA;
      end
      ST_RDATA: if (scl_fall) begin
        shreg_d = {shreg_q[6:0], 1'b0};
        cnt_d = cnt_q + `SMBC_CNT_ONE;
        if (cnt_q == `SMBC_LAST_BIT) begin
          ptr_d = ptr_q + `SMBC_PTR_ONE;
          cnt_d = `SMBC_CNT_ZERO;
          state_d = ST_MACK;
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          shreg_d[0] = smb_i.sda;
        end
        if (scl_fall) begin
          // nack ends the read; ack streams the next offset
          state_d = shreg_q[0] ? ST_IDLE : ST_RDATA;
          shreg_d = rd_data;
        end
      end
      default: ;
    endcase
    if (start_c) begin
      state_d = ST_ADDR;
      cnt_d = `SMBC_CNT_ZERO;
    end else if (stop_c) begin
      state_d = ST_IDLE;
    end
  end

  assign oe_d = (state_d == ST_AACK) | (state_d == ST_PACK) | (state_d == ST_DACK) |
                ((state_d == ST_RDATA) & ~shreg_d[7]);

  always_ff @(posedge ref_clk_i) begin
    scl_q <= rst_i | smb_i.scl;
    sda_q <= rst_i | smb_i.sda;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      shreg_q <= `SMBC_ZERO;
      cnt_q <= `SMBC_CNT_ZERO;
      ptr_q <= `SMBC_ZERO;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      oe_q <= oe_d;
    end
  end

  // ---------------------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || soft_rst) begin
      power_down_pin_q <= `SMBC_ZERO;
      ovr_q <= `SMBC_ZERO;
      ctl_q <= `SMBC_CTL_RST;
      obs7_q <= 1'b0;
    end else if (wr_en) begin
      if (ptr_q == `SMBC_REG_OBS) begin
        obs7_q <= shreg_q[`SMBC_OBS_RSVD_BIT];
      end else if (ptr_q == `SMBC_REG_POWER_DOWN_PIN) begin
        power_down_pin_q <= shreg_q;
      end else if (ptr_q == `SMBC_REG_OVR) begin
        ovr_q <= shreg_q;
      end else if (ptr_q == `SMBC_REG_CTL) begin
        ctl_q <= shreg_q;
      end
    end
  end

  for (genvar g = 0; g < `SMBC_RSVD_CNT; g++) begin : g_rsvd
    always_ff @(posedge ref_clk_i) begin
      if (rst_i || soft_rst) begin
        rsvd_q[g] <= `SMBC_ZERO;
      end else if (wr_en && in_rsvd && ridx == 8'(g)) begin
        rsvd_q[g] <= shreg_q;
      end
    end
  end

  // pin keeps control until software takes over; each set bit kills a lane
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      chan_off_q <= `SMBC_ZERO;
    end else begin
      chan_off_q <= ovr_q[`SMBC_OVR_BIT] ? power_down_pin_q : {8{power_down_pin_i}};
    end
  end

  assign chan_off_o = chan_off_q;
  assign reg_ctl_en_o = ctl_q[`SMBC_CTL_EN_BIT];
  assign smb_sda_oe_o = oe_q;
  assign smb_sda_o = 1'b0;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire obs_load = (state_q == ST_AACK) && scl_fall && shreg_q[0] && !start_c && !stop_c
                  && ptr_q == `SMBC_REG_OBS;

  AST_OBS_STRAP: assert property (obs_load |=> shreg_q[6:3] == $past(strap_i))
    else $error("strap bits not loaded");
  AST_OBS_DONE: assert property (obs_load |=> shreg_q[2] == $past(eeprom_done_i))
    else $error("load-done bit not loaded");
  AST_SOFT_RST: assert property (soft_rst |=> power_down_pin_q == `SMBC_ZERO
    && ovr_q == `SMBC_ZERO && ctl_q == `SMBC_CTL_RST)
    else $error("soft reset missed");
  AST_BLOCK: assert property ((obs_wr && shreg_q[`SMBC_OBS_BLK_BIT]) |=>
    $stable(power_down_pin_q) && $stable(ctl_q) && $stable(ovr_q))
    else $error("blocked reset changed registers");
  AST_POWER_DOWN_PIN_WR: assert property ((wr_en && ptr_q == `SMBC_REG_POWER_DOWN_PIN) |=>
    power_down_pin_q == $past(shreg_q))
    else $error("power-down write lost");
  AST_OVR_REG: assert property (ovr_q[`SMBC_OVR_BIT] && $stable(power_down_pin_q) |=>
    chan_off_o == $past(power_down_pin_q))
    else $error("override not honoured");
  AST_OVR_PIN: assert property (!ovr_q[`SMBC_OVR_BIT] |=>
    chan_off_o == {8{$past(power_down_pin_i)}})
    else $error("pin control not honoured");
  AST_CTL_EN: assert property ((wr_en && ptr_q == `SMBC_REG_CTL) |=>
    reg_ctl_en_o == $past(shreg_q[`SMBC_CTL_EN_BIT]))
    else $error("enable bit not taken");
  AST_ADDR_MISS: assert property ((state_q == ST_ADDR && byte_done
    && !addr_hit && !start_c) |=> !smb_sda_oe_o [*2])
    else $error("acked foreign address");
  AST_ADDR_HIT: assert property ((state_q == ST_ADDR && byte_done
    && addr_hit && !start_c) |=> smb_sda_oe_o)
    else $error("own address not acked");
  AST_READ_NACK: assert property ((state_q == ST_MACK && scl_fall && shreg_q[0]
    && !start_c && !stop_c) |=> state_q == ST_IDLE && !smb_sda_oe_o)
    else $error("read not ended on nack");
endmodule : smbc_bank

// file: verif/smbc_host_model.sv
/*
  SMBus host model: drives SCL and its share of SDA with slow phases.
  Assumes the device enable arrives on dev_oe_i; SDA has a pull-up.
*/
`timescale 1ns/1ps
module smbc_host_model (
  input wire logic ref_clk_i,
  input wire logic dev_oe_i,
  output smbc_pkg::smbc_bus_t smb_o
);
  import smbc_pkg::*;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int half = 4;
  // released wire reads the pull-up level; one driver for the whole struct
  assign smb_o = {scl_q, sda_q & ~dev_oe_i};
  // ----------
  // bus steps
  // ----------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  // sda moves only while scl low
  task automatic bit_io(input logic b, output logic r);
    sda_q = b;
    tick(half);
    scl_q = 1'b1;
    tick(half);
    r = smb_o.sda;
    scl_q = 1'b0;
    tick(1);
  endtask : bit_io
  task automatic start();
    sda_q = 1'b1;
    tick(half);
    scl_q = 1'b1;
    tick(half);
    sda_q = 1'b0;
    tick(half);
    scl_q = 1'b0;
    tick(1);
  endtask : start
  task automatic stop();
    sda_q = 1'b0;
    tick(half);
    scl_q = 1'b1;
    tick(half);
    sda_q = 1'b1;
    tick(half);
  endtask : stop
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send_byte
  task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
      output logic ok);
    logic k1, k2, k3;
    start();
    send_byte(a, k1);
    send_byte(p, k2);
    send_byte(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask : wr
  // pointer, repeated start, one byte, nack, stop
  task automatic rd(input logic [7:0] a, input logic [7:0] p, output logic [7:0] d,
      output logic ok);
    logic k1, k2, k3, r;
    start();
    send_byte(a, k1);
    send_byte(p, k2);
    start();
    send_byte(a | 8'h01, k3);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
    stop();
    ok = k1 & k2 & k3;
  endtask : rd
endmodule : smbc_host_model

// file: verif/tb.sv
/*
  Self-checking bench of the SMBus bank with random straps, pin and values.
  Assumes the host model owns the bus.
*/
`timescale 1ns/1ps
module tb;
  import smbc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] strap = 4'h0;
  logic done = 1'b0;
  logic pin = 1'b0;
  smbc_bus_t smb;
  logic sda_o, oe, ctl_en, ok, ovr;
  logic [7:0] off, d, v;
  int n_errors = 0;
  int n_tests = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  smbc_bank dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .smb_i(smb), .smb_sda_o(sda_o),
    .smb_sda_oe_o(oe), .strap_i(strap), .eeprom_done_i(done), .power_down_pin_i(pin),
    .chan_off_o(off), .reg_ctl_en_o(ctl_en));
  smbc_host_model host (.ref_clk_i(ref_clk_i), .dev_oe_i(oe), .smb_o(smb));
  function automatic logic [7:0] dev_addr(input logic [3:0] s);
    return 8'hB0 + {3'h0, s, 1'b0};
  endfunction : dev_addr
  function automatic logic [7:0] obs_val(input logic [3:0] s, input logic e);
    return {1'b0, s, e, 2'h0};
  endfunction : obs_val
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [7:0] dat);
    host.wr(dev_addr(strap), p, dat, ok);
    chk({7'h0, ok}, 8'h01);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    host.rd(dev_addr(strap), p, v, ok);
    chk({7'h0, ok}, 8'h01);
    chk(v, exp);
  endtask : rd
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // about four times the length of the planned transfers
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_errors++;
    give_verdict();
  end
  // ----------
  // tests
  // ----------
  initial begin
    void'($urandom(32'hdf4b));
    repeat (12) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    rd(8'h06, 8'h10);
    chk({7'h0, ctl_en}, 8'h00);
    chk({7'h0, sda_o}, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h07, 8'h00);
    $display("test defaults done");
    for (int i = 0; i < 6; i++) begin
      strap = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
      done = 1'($urandom);
      rd(8'h00, obs_val(strap, done));
      host.wr(dev_addr(strap ^ 4'h1), 8'h01, 8'hFF, ok);
      chk({7'h0, ok}, 8'h00);
    end
    rd(8'h01, 8'h00);
    $display("test address done");
    for (int i = 0; i < 10; i++) begin
      d = (i < 2) ? 8'h00 : (i < 4) ? 8'hFF : 8'($urandom);
      ovr = i[0];
      wr(8'h02, {7'h0, ovr});
      wr(8'h01, d);
      pin = 1'($urandom);
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk(off, ovr ? d : {8{pin}});
    end
    rd(8'h01, d);
    $display("test power down done");
    wr(8'h06, 8'h18);
    chk({7'h0, ctl_en}, 8'h01);
    rd(8'h06, 8'h18);
    wr(8'h06, 8'h10);
    chk({7'h0, ctl_en}, 8'h00);
    $display("test control done");
    wr(8'h06, 8'h18);
    wr(8'h02, 8'h01);
    wr(8'h01, 8'hA5);
    wr(8'h00, 8'h03);
    rd(8'h01, 8'hA5);
    rd(8'h00, obs_val(strap, done));
    chk({7'h0, ctl_en}, 8'h01);
    wr(8'h00, 8'h01);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h06, 8'h10);
    chk({7'h0, ctl_en}, 8'h00);
    $display("test soft reset done");
    give_verdict();
  end
endmodule : tb
